// ### pkg/scpd_cfg.svh
`ifndef SCPD_CFG_SVH
`define SCPD_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SCPD_A_MAIN  4'h0
`define SCPD_A_GAIN  4'h1
`define SCPD_A_PWR   4'h2
`define SCPD_A_RF1N  4'h3
`define SCPD_A_RF2N  4'h4
`define SCPD_A_IFN   4'h5
`define SCPD_A_RF1R  4'h6
`define SCPD_A_RF2R  4'h7
`define SCPD_A_IFR   4'h8

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define SCPD_FRAME_BITS 22
`define SCPD_ADDR_BITS  4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCPD_AUX_HI   13
`define SCPD_AUX_LO   12
`define SCPD_IF_OUTPUT_DIVIDER_HI 11
`define SCPD_IF_OUTPUT_DIVIDER_LO 10
`define SCPD_HALF_BIT 6
`define SCPD_IF_LOW_POWER_BIT_BIT 5
`define SCPD_AUTO_BIT 3
`define SCPD_PDI_BIT  1
`define SCPD_PDR_BIT  0
`define SCPD_KPI_HI   5
`define SCPD_KPI_LO   4
`define SCPD_KP2_HI   3
`define SCPD_KP2_LO   2
`define SCPD_KP1_HI   1
`define SCPD_KP1_LO   0

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define SCPD_AUX_LOW  2'h1
`define SCPD_AUX_LDET 2'h3
`define SCPD_REG_RST  18'h00000

`endif

// ### pkg/scpd_pkg.sv
package scpd_pkg;
  // Register word, address and serial frame
  typedef logic [17:0] scpd_word_t;
  typedef logic [3:0]  scpd_addr_t;
  typedef logic [21:0] scpd_frame_t;
  // Which RF oscillator feeds the RF output amplifier
  typedef enum logic {SCPD_VCO_RF1, SCPD_VCO_RF2} scpd_vco_t;
endpackage

// ### pkg/scpd_link_if.sv
`timescale 1ns/10ps
// ----------------------------------------
// Shifter to control-domain word carrier
// ----------------------------------------
interface scpd_link_if;
  import scpd_pkg::*;
  scpd_frame_t frame;
  modport shifter (output frame);
  modport ctrl    (input  frame);
endinterface

// ### hw/scpd_sync.sv
`timescale 1ns/10ps
// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module scpd_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // scpd_sync

// ### hw/scpd_shift.sv
`timescale 1ns/10ps
`include "scpd_cfg.svh"
// ----------------------------------------
// Serial shifter on the link clock
// ----------------------------------------
module scpd_shift
  import scpd_pkg::*;
(
  input  wire logic  sclk,
  input  wire logic  rst,
  input  wire logic  sdata,
  input  wire logic  sen_n,
  scpd_link_if.shifter link
);
  scpd_frame_t shift_reg;

  // Shift only inside a frame; word holds still once enable rises,
  // since shifting is gated by the frame enable
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (!sen_n) begin
      shift_reg <= {shift_reg[`SCPD_FRAME_BITS-2:0], sdata};
    end
  end

  assign link.frame = shift_reg;
endmodule // scpd_shift

// ### hw/scpd_top.sv
`timescale 1ns/10ps
`include "scpd_cfg.svh"
module scpd_top
  import scpd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        sen_n,
  input  wire logic        powerdown_pin_n,
  input  wire logic        if_tuning,
  input  wire logic        rf_tuning,
  input  wire logic        if_near_limit,
  input  wire logic        rf_near_limit,
  output logic             rf2_vco_selected,
  output logic             if_power_on,
  output logic             rf_power_on,
  output logic             ref_amp_on,
  output logic             if_low_power_bit,
  output logic             aux_output_pin,
  output logic [1:0]       if_output_divider,
  output logic             ref_halving_bit,
  output logic [1:0]       if_loop_gain,
  output logic [1:0]       rf1_loop_gain,
  output logic [1:0]       rf2_loop_gain,
  output logic [17:0]      rf1_feedback_count,
  output logic [16:0]      rf2_feedback_count,
  output logic [15:0]      if_feedback_count,
  output logic [12:0]      rf1_ref_count,
  output logic [12:0]      rf2_ref_count,
  output logic [12:0]      if_ref_count,
  output logic             rf_retune,
  output logic             if_retune
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Section power from pin, auto bit and own enable
  function automatic logic sect_on(input logic pin, input logic auto_on,
                                   input logic enable);
    return pin && (auto_on || enable);
  endfunction

  // Address belongs to the given divider pair (its N or R address)
  function automatic logic is_rf_div(input scpd_addr_t a,
                                     input scpd_addr_t n_addr,
                                     input scpd_addr_t r_addr);
    return (a == n_addr) || (a == r_addr);
  endfunction

  // ----------------------------------------
  // Link domain and synchronisers
  // ----------------------------------------
  scpd_link_if link ();

  scpd_shift u_shift (
    .sclk  (sclk),
    .rst   (rst),
    .sdata (sdata),
    .sen_n (sen_n),
    .link  (link.shifter)
  );

  logic [5:0] sync_q;

  scpd_sync #(.W(6)) u_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({!sen_n, powerdown_pin_n, if_tuning, rf_tuning,
           if_near_limit, rf_near_limit}),
    .q   (sync_q)
  );

  logic sen_s;
  logic pin_s;
  logic warn_any;
  logic sen_last_reg;
  // Synced as frame-active: reset 0 is the idle level, no false commit
  assign sen_s    = !sync_q[5];
  assign pin_s    = sync_q[4];
  // Lock warning raised by tuning or range edge of either loop
  assign warn_any = |sync_q[3:0];

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  logic       wr_pulse_reg;
  scpd_addr_t wr_addr_reg;
  scpd_word_t wr_data_reg;

  // Enable rise ends a frame; the shifter word is static by then
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sen_last_reg <= 1'b1;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= '0;
      wr_data_reg  <= '0;
    end else begin
      sen_last_reg <= sen_s;
      wr_pulse_reg <= sen_s && !sen_last_reg;
      if (sen_s && !sen_last_reg) begin
        wr_addr_reg <= link.frame[`SCPD_ADDR_BITS-1:0];
        wr_data_reg <= link.frame[`SCPD_FRAME_BITS-1:`SCPD_ADDR_BITS];
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  scpd_word_t main_config_reg;
  scpd_word_t loop_gain_select_reg;
  scpd_word_t section_power_ctl_reg;
  scpd_word_t rf1_feedback_div_reg;
  scpd_word_t rf2_feedback_div_reg;
  scpd_word_t if_feedback_div_reg;
  scpd_word_t rf1_ref_div_reg;
  scpd_word_t rf2_ref_div_reg;
  scpd_word_t if_ref_div_reg;

  // addresses above eight match no case and are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      main_config_reg       <= `SCPD_REG_RST;
      loop_gain_select_reg  <= `SCPD_REG_RST;
      section_power_ctl_reg <= `SCPD_REG_RST;
      rf1_feedback_div_reg  <= `SCPD_REG_RST;
      rf2_feedback_div_reg  <= `SCPD_REG_RST;
      if_feedback_div_reg   <= `SCPD_REG_RST;
      rf1_ref_div_reg       <= `SCPD_REG_RST;
      rf2_ref_div_reg       <= `SCPD_REG_RST;
      if_ref_div_reg        <= `SCPD_REG_RST;
    end else if (wr_pulse_reg) begin
      case (wr_addr_reg)
        `SCPD_A_MAIN: main_config_reg       <= wr_data_reg;
        `SCPD_A_GAIN: loop_gain_select_reg  <= wr_data_reg;
        `SCPD_A_PWR:  section_power_ctl_reg <= wr_data_reg;
        `SCPD_A_RF1N: rf1_feedback_div_reg  <= wr_data_reg;
        `SCPD_A_RF2N: rf2_feedback_div_reg  <= wr_data_reg;
        `SCPD_A_IFN:  if_feedback_div_reg   <= wr_data_reg;
        `SCPD_A_RF1R: rf1_ref_div_reg       <= wr_data_reg;
        `SCPD_A_RF2R: rf2_ref_div_reg       <= wr_data_reg;
        `SCPD_A_IFR:  if_ref_div_reg        <= wr_data_reg;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // RF oscillator selection
  // ----------------------------------------
  scpd_vco_t vco_reg;

  // last RF1 or RF2 divider write picks the oscillator; IF writes leave it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vco_reg <= SCPD_VCO_RF1;
    end else if (wr_pulse_reg) begin
      if (is_rf_div(wr_addr_reg, `SCPD_A_RF1N, `SCPD_A_RF1R)) begin
        vco_reg <= SCPD_VCO_RF1;
      end else if (is_rf_div(wr_addr_reg, `SCPD_A_RF2N,
                             `SCPD_A_RF2R)) begin
        vco_reg <= SCPD_VCO_RF2;
      end
    end
  end

  assign rf2_vco_selected = (vco_reg == SCPD_VCO_RF2);

  // ----------------------------------------
  // Power management
  // ----------------------------------------
  logic auto_on;
  logic if_en;
  logic rf_en;
  logic if_power_next;
  logic rf_power_next;
  logic ref_amp_next;
  assign auto_on = main_config_reg[`SCPD_AUTO_BIT];
  assign if_en   = section_power_ctl_reg[`SCPD_PDI_BIT];
  assign rf_en   = section_power_ctl_reg[`SCPD_PDR_BIT];

  // pin high defers to the register bits
  // each enable governs its own section
  // auto bit forces both sections on
  assign if_power_next = sect_on(pin_s, auto_on, if_en);
  assign rf_power_next = sect_on(pin_s, auto_on, rf_en);
  assign ref_amp_next  = if_power_next || rf_power_next;

  // Registered so every pin comes from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      if_power_on <= 1'b0;
      rf_power_on <= 1'b0;
      ref_amp_on  <= 1'b0;
    end else begin
      if_power_on <= if_power_next;
      rf_power_on <= rf_power_next;
      ref_amp_on  <= ref_amp_next;
    end
  end

  // ----------------------------------------
  // Retune requests
  // ----------------------------------------
  logic rf_div_wr;
  logic if_div_wr;
  assign rf_div_wr = wr_pulse_reg &&
    (is_rf_div(wr_addr_reg, `SCPD_A_RF1N, `SCPD_A_RF1R) ||
     is_rf_div(wr_addr_reg, `SCPD_A_RF2N, `SCPD_A_RF2R));
  assign if_div_wr = wr_pulse_reg &&
    is_rf_div(wr_addr_reg, `SCPD_A_IFN, `SCPD_A_IFR);

  // Self-tuning starts on section power-up or a new frequency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rf_retune <= 1'b0;
      if_retune <= 1'b0;
    end else begin
      rf_retune <= (rf_power_next && !rf_power_on) || rf_div_wr;
      if_retune <= (if_power_next && !if_power_on) || if_div_wr;
    end
  end

  // ----------------------------------------
  // Auxiliary output and IF options
  // ----------------------------------------
  logic [1:0] aux_sel;
  logic       aux_next;
  assign aux_sel = main_config_reg[`SCPD_AUX_HI:`SCPD_AUX_LO];

  // aux pin source chosen by select field
  // reserved and unlisted codes also drive low
  // warning level comes from tuning and range flags
  // warning shown so the host can retune
  always_comb begin
    aux_next = 1'b0;
    if (aux_sel == `SCPD_AUX_LDET) begin
      aux_next = warn_any;
    end
  end

  // low-power bit lowers IF amplifier bias
  // divider code passed to the IF output stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux_output_pin    <= 1'b0;
      if_low_power_bit  <= 1'b0;
      if_output_divider <= 2'h0;
      ref_halving_bit   <= 1'b0;
    end else begin
      aux_output_pin    <= aux_next;
      if_low_power_bit  <= main_config_reg[`SCPD_IF_LOW_POWER_BIT_BIT];
      if_output_divider <=
        main_config_reg[`SCPD_IF_OUTPUT_DIVIDER_HI:`SCPD_IF_OUTPUT_DIVIDER_LO];
      ref_halving_bit   <= main_config_reg[`SCPD_HALF_BIT];
    end
  end

  // ----------------------------------------
  // Divider and gain fields
  // ----------------------------------------
  // Fields are slices of flops, so outputs stay flop driven
  assign if_loop_gain  =
    loop_gain_select_reg[`SCPD_KPI_HI:`SCPD_KPI_LO];
  assign rf2_loop_gain =
    loop_gain_select_reg[`SCPD_KP2_HI:`SCPD_KP2_LO];
  assign rf1_loop_gain =
    loop_gain_select_reg[`SCPD_KP1_HI:`SCPD_KP1_LO];
  assign rf1_feedback_count = rf1_feedback_div_reg;
  assign rf2_feedback_count = rf2_feedback_div_reg[16:0];
  assign if_feedback_count  = if_feedback_div_reg[15:0];
  assign rf1_ref_count      = rf1_ref_div_reg[12:0];
  assign rf2_ref_count      = rf2_ref_div_reg[12:0];
  assign if_ref_count       = if_ref_div_reg[12:0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_VCO_RF2:
    assert property (@(posedge ref_clk) disable iff (rst)
      wr_pulse_reg && (wr_addr_reg == `SCPD_A_RF2R)
      |=> rf2_vco_selected ##0 rf2_vco_selected [*1])
    else $error("RF2 divider write did not select RF2");

  AST_VCO_RF1:
    assert property (@(posedge ref_clk) disable iff (rst)
      wr_pulse_reg && (wr_addr_reg == `SCPD_A_RF1N)
      |=> !rf2_vco_selected)
    else $error("RF1 divider write did not select RF1");

  AST_LOW_POWER:
    assert property (@(posedge ref_clk) disable iff (rst)
      wr_pulse_reg && (wr_addr_reg == `SCPD_A_MAIN)
      |=> ##1 (if_low_power_bit == $past(wr_data_reg[5], 2)))
    else $error("IF low-power output does not follow its bit");

  AST_PIN_OFF:
    assert property (@(posedge ref_clk) disable iff (rst)
      !pin_s [*2] |-> !if_power_on && !rf_power_on && !ref_amp_on)
    else $error("Section powered while pin is low");

  AST_SW_IF_OFF:
    assert property (@(posedge ref_clk) disable iff (rst)
      pin_s && !auto_on && !if_en && rf_en
      |=> !if_power_on && rf_power_on)
    else $error("Section enables not independent");

  AST_AUTO_ON:
    assert property (@(posedge ref_clk) disable iff (rst)
      pin_s && auto_on |=> if_power_on && rf_power_on)
    else $error("Auto bit did not power both sections");

  AST_REF_AMP:
    assert property (@(posedge ref_clk) disable iff (rst)
      ref_amp_on == $past(pin_s && (auto_on || if_en || rf_en)))
    else $error("Reference amplifier state wrong");

  AST_WRITE_IN_PD:
    assert property (@(posedge ref_clk) disable iff (rst)
      wr_pulse_reg && !pin_s && (wr_addr_reg == `SCPD_A_PWR)
      |=> section_power_ctl_reg == $past(wr_data_reg))
    else $error("Write lost during powerdown");

  AST_RESV_DROP:
    assert property (@(posedge ref_clk) disable iff (rst)
      wr_pulse_reg && (wr_addr_reg > `SCPD_A_IFR)
      |=> $stable(main_config_reg) && $stable(if_ref_div_reg))
    else $error("Reserved address altered a register");

  AST_AUX_LOW:
    assert property (@(posedge ref_clk) disable iff (rst)
      (aux_sel == `SCPD_AUX_LOW) |=> !aux_output_pin)
    else $error("Aux pin not forced low");

  AST_LOCK_WARN:
    assert property (@(posedge ref_clk) disable iff (rst)
      (aux_sel == `SCPD_AUX_LDET) |=> aux_output_pin == $past(warn_any))
    else $error("Aux pin does not show lock warning");

  AST_IF_DIV:
    assert property (@(posedge ref_clk) disable iff (rst)
      if_output_divider ==
        $past(main_config_reg[`SCPD_IF_OUTPUT_DIVIDER_HI:`SCPD_IF_OUTPUT_DIVIDER_LO]))
    else $error("IF divider code not passed on");

endmodule // scpd_top

// ### tb/scpd_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the serial control link
// ----------------------------------------
module scpd_host_model
  import scpd_pkg::*;
(
  output logic sclk,
  output logic sdata,
  output logic sen_n
);
  // Link idle: clock parked low, frame closed
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
    sen_n = 1'b1;
  end

  // One frame, data MSB first then address; slow stretches low phase
  task automatic send(input scpd_addr_t a, input scpd_word_t d,
                      input int slow, input bit rsv);
    scpd_frame_t f;
    f = {d, a};
    if (a > 4'h8 && !rsv) begin
      return;
    end
    #13;
    sen_n = 1'b0;
    for (int i = 21; i >= 0; i--) begin
      sdata = f[i];
      #(40 + slow);
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
    end
    #40;
    sen_n = 1'b1;
    // Released line must not keep a stale bit
    sdata = ~sdata;
    #300;
  endtask
endmodule // scpd_host_model

// ### tb/synth_control_and_powerdown_tb.sv
`timescale 1ns/10ps
`include "scpd_cfg.svh"
module synth_control_and_powerdown_tb;
  import scpd_pkg::*;
  logic        ref_clk, rst, powerdown_pin_n;
  logic [3:0]  stat;
  wire logic   if_tuning, rf_tuning, if_near_limit, rf_near_limit;
  logic        sclk, sdata, sen_n, rf2_vco_selected;
  logic        if_power_on, rf_power_on, ref_amp_on, if_low_power_bit;
  logic        aux_output_pin, ref_halving_bit, rf_retune, if_retune;
  logic [1:0]  if_output_divider, if_loop_gain;
  logic [1:0]  rf1_loop_gain, rf2_loop_gain;
  logic [17:0] rf1_feedback_count;
  logic [16:0] rf2_feedback_count;
  logic [15:0] if_feedback_count;
  logic [12:0] rf1_ref_count, rf2_ref_count, if_ref_count;
  int          num_errors, checks, rf_pulses, if_pulses;
  scpd_word_t  exp_reg [0:8];
  logic        exp_rf2;

  assign {rf_near_limit, if_near_limit, rf_tuning, if_tuning} = stat;

  scpd_host_model i_host (.sclk, .sdata, .sen_n);

  scpd_top i_dut (
    .ref_clk, .rst, .sclk, .sdata, .sen_n, .powerdown_pin_n,
    .if_tuning, .rf_tuning, .if_near_limit, .rf_near_limit,
    .rf2_vco_selected, .if_power_on, .rf_power_on, .ref_amp_on,
    .if_low_power_bit, .aux_output_pin, .if_output_divider,
    .ref_halving_bit, .if_loop_gain, .rf1_loop_gain, .rf2_loop_gain,
    .rf1_feedback_count, .rf2_feedback_count, .if_feedback_count,
    .rf1_ref_count, .rf2_ref_count, .if_ref_count,
    .rf_retune, .if_retune
  );

  // 20 MHz control clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Pulses counted mid-cycle to stay clear of the launching edge
  always @(negedge ref_clk) begin
    if (rf_retune === 1'b1) rf_pulses++;
    if (if_retune === 1'b1) if_pulses++;
  end

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Expected {IF, RF} section power
  function automatic logic [1:0] pwr(input logic pin, input logic auto_on,
                                     input scpd_word_t p);
    if (pin !== 1'b1) return 2'b00;
    if (auto_on) return 2'b11;
    return {p[`SCPD_PDI_BIT], p[`SCPD_PDR_BIT]};
  endfunction

  task automatic wr(input scpd_addr_t a, input scpd_word_t d, input bit rsv);
    i_host.send(a, d, 100 * $urandom_range(1), rsv);
    if (a < 4'h9) begin
      exp_reg[a] = d;
      if (a == `SCPD_A_RF1N || a == `SCPD_A_RF1R) exp_rf2 = 1'b0;
      if (a == `SCPD_A_RF2N || a == `SCPD_A_RF2R) exp_rf2 = 1'b1;
    end
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic drive(input logic pin, input logic [3:0] s);
    @(posedge ref_clk);
    #1;
    powerdown_pin_n = pin;
    stat = s;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic check_all();
    scpd_word_t m;
    logic [1:0] p;
    m = exp_reg[0];
    p = pwr(powerdown_pin_n, m[`SCPD_AUTO_BIT], exp_reg[2]);
    chk(18'(if_power_on), 18'(p[1]));
    chk(18'(rf_power_on), 18'(p[0]));
    chk(18'(ref_amp_on), 18'(|p));
    chk(18'(if_low_power_bit), 18'(m[`SCPD_IF_LOW_POWER_BIT_BIT]));
    chk(18'(if_output_divider), 18'(m[11:10]));
    chk(18'(ref_halving_bit), 18'(m[`SCPD_HALF_BIT]));
    chk(18'(aux_output_pin), 18'((m[13:12] == `SCPD_AUX_LDET) & |stat));
    chk(18'(rf2_vco_selected), 18'(exp_rf2));
    chk(18'({if_loop_gain, rf2_loop_gain, rf1_loop_gain}),
        18'(exp_reg[1][5:0]));
    chk(rf1_feedback_count, exp_reg[3]);
    chk(18'(rf2_feedback_count), 18'(exp_reg[4][16:0]));
    chk(18'(if_feedback_count), 18'(exp_reg[5][15:0]));
    chk(18'(rf1_ref_count), 18'(exp_reg[6][12:0]));
    chk(18'(rf2_ref_count), 18'(exp_reg[7][12:0]));
    chk(18'(if_ref_count), 18'(exp_reg[8][12:0]));
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run of about 200 us
  initial begin
    #1_000_000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    scpd_word_t m;
    int b_rf;
    int b_if;
    rst = 1'b1;
    powerdown_pin_n = 1'b0;
    stat = 4'h0;
    exp_rf2 = 1'b0;
    foreach (exp_reg[i]) exp_reg[i] = `SCPD_REG_RST;
    void'($urandom(58854));
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    drive(1'b0, 4'h0);
    check_all();
    // Power table; writes land while the pin holds all off
    for (int k = 0; k < 8; k++) begin
      drive(1'b0, 4'h0);
      m = scpd_word_t'($urandom) & 18'h03C60;
      m[`SCPD_AUTO_BIT] = k[2];
      wr(`SCPD_A_MAIN, m, 1'b0);
      wr(`SCPD_A_PWR, {16'h0000, k[1:0]}, 1'b0);
      check_all();
      drive(1'b1, 4'h0);
      check_all();
    end
    // Every aux code against each status flag alone
    for (int c = 0; c < 4; c++) begin
      m = exp_reg[0];
      m[13:12] = c[1:0];
      wr(`SCPD_A_MAIN, m, 1'b0);
      for (int s = 0; s < 6; s++) begin
        drive(1'b1, s == 5 ? 4'($urandom) : 4'((1 << s) >> 1));
        check_all();
      end
    end
    // Divider and gain writes, extremes first
    wr(`SCPD_A_RF1N, 18'h3FFFF, 1'b0);
    wr(`SCPD_A_RF2R, 18'h00000, 1'b0);
    check_all();
    repeat (30) begin
      m = scpd_word_t'($urandom);
      if ($urandom_range(5) == 0) begin
        wr(`SCPD_A_GAIN, m, 1'b0);
      end else begin
        wr(4'($urandom_range(8, 3)), m, 1'b0);
      end
      check_all();
    end
    // Reserved addresses must leave everything alone
    for (int r = 9; r < 16; r++) begin
      wr(4'(r), scpd_word_t'($urandom), 1'b1);
      check_all();
    end
    // Retune request follows a divider write of that loop only
    b_rf = rf_pulses;
    b_if = if_pulses;
    wr(`SCPD_A_RF1N, 18'h01000, 1'b0);
    chk(18'(rf_pulses - b_rf), 18'h00001);
    chk(18'(if_pulses - b_if), 18'h00000);
    b_rf = rf_pulses;
    wr(`SCPD_A_IFR, 18'h00020, 1'b0);
    chk(18'(if_pulses - b_if), 18'h00001);
    chk(18'(rf_pulses - b_rf), 18'h00000);
    check_all();
    report_and_stop();
  end
endmodule // synth_control_and_powerdown_tb
